// file: include/edi_pkg.sv
//----------------------------------------------------------------------
// Behaviour
// (RULE_01) raise input increases selected mode reference
// (RULE_02) lower input decreases selected mode reference
// (RULE_03) test raise only under forced drive, digital input
// (RULE_04) test lower only under forced drive, digital input
// (RULE_05) four mode commands honoured in digital input
// (RULE_06) remote bus command activates bus, permission optional
// (RULE_07) forcing input gives digital inputs top precedence
// (RULE_08) unload request starts timed reactive unloading
// (RULE_09) reset input clears latched trip conditions
// (RULE_10) switchgear reports field breaker closed state
// (RULE_11) excitation off command switches excitation off
// (RULE_12) excitation on command switches excitation on
// (RULE_13) open command orders breaker open, digital input
// (RULE_14) close command orders breaker close, digital input
// (RULE_15) incoming trip waits stopping time, then trips
// (RULE_16) phase retard first, breaker opened afterwards
// (RULE_17) digital input control takes commands from inputs
// (RULE_18) inputs synchronised, debounced, commands act on edges
// (RULE_19) gated commands ignored, not latched, outside mode
//----------------------------------------------------------------------
package edi_pkg;

   //-------------------------------------------------------------------
   // timing
   //-------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int MS_PS         = 1000000000;
   localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
   localparam int DEB_TIME_NS   = 5000;
   // least time, so round up
   localparam int DEB_CYCLES    =
      (DEB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIME_W        = 16;

   //-------------------------------------------------------------------
   // modes and states
   //-------------------------------------------------------------------
   typedef enum logic [1:0] {
      CTRL_PANEL,
      CTRL_DIGITAL_INPUT,
      CTRL_BUS
   } edi_ctrl_e;

   typedef enum logic [1:0] {
      DRIVE_NORMAL,
      DRIVE_FORCED_VALUE,
      DRIVE_OPEN_LOOP_REF
   } edi_drive_e;

   typedef enum logic [1:0] {
      MODE_VOLTAGE,
      MODE_FIELD_CURRENT,
      MODE_REACTIVE,
      MODE_POWER_FACTOR
   } edi_reg_mode_e;

   typedef enum logic [1:0] {
      TRIP_IDLE,
      TRIP_RETARD,
      TRIP_OPEN
   } edi_trip_e;

   localparam edi_reg_mode_e RST_REG_MODE = MODE_VOLTAGE;

   //-------------------------------------------------------------------
   // carriers
   //-------------------------------------------------------------------
   typedef struct packed {
      logic raise;
      logic lower;
      logic test_raise;
      logic test_lower;
      logic cmd_voltage;
      logic cmd_field;
      logic cmd_reactive;
      logic cmd_pf;
      logic remote_bus;
      logic force_di;
      logic unload_q;
      logic trip_reset;
      logic fb_closed;
      logic exc_off;
      logic exc_on;
      logic open_fb;
      logic close_fb;
      logic incoming_trip;
   } edi_di_s;

   localparam int DI_W = $bits(edi_di_s);

   typedef struct packed {
      edi_ctrl_e         ctrl_mode;
      edi_drive_e        force_drive;
      logic              remote_permit_req;
      logic              remote_permit;
      logic [TIME_W-1:0] unload_timeout_ms;
      logic [TIME_W-1:0] stop_time_ms;
   } edi_cfg_s;

   typedef struct packed {
      logic          ref_raise;
      logic          ref_lower;
      edi_reg_mode_e reg_mode;
      logic          digital_input_control;
      logic          bus_active;
      logic          unload_active;
      logic          unload_timed_out;
      logic          trip_latched;
      logic          exc_on;
      logic          fb_closed;
      logic          fb_open_order;
      logic          fb_close_order;
      logic          phase_retard;
      logic          fb_trip;
   } edi_stat_s;

endpackage

// file: verif/edi_handler_props.sv
`timescale 1ns/10ps
module edi_handler_props
   import edi_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES
) (
   input wire logic      SYS_CLK,
   input wire logic      NRST,
   input wire edi_di_s   DI_IN,
   input wire edi_cfg_s  CFG,
   input wire logic      EXC_TRIP_IN,
   input wire edi_stat_s STAT
);
   //---------------------------------------------
   // checks
   //---------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   int rcnt;
   // retard length, cleared whenever retard is off
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         rcnt <= 0;
      else
         rcnt <= STAT.phase_retard ? rcnt + 1 : 0;
   end
   a_ref_excl: assert property (
      !(STAT.ref_raise && STAT.ref_lower))
      else $error("raise and lower both on");
   a_order_excl: assert property (
      !(STAT.fb_open_order && STAT.fb_close_order))
      else $error("open and close order together");
   a_retard_first: assert property (
      $rose(STAT.fb_trip) |-> $past(STAT.phase_retard))
      else $error("breaker tripped without retard");
   a_retard_len: assert property (
      $fell(STAT.phase_retard) |->
      rcnt + 1 >= CFG.stop_time_ms * MS_TICK_CYCLES - 1 &&
      rcnt <= (CFG.stop_time_ms + 1) * MS_TICK_CYCLES + 1)
      else $error("stopping time wrong");
   a_trip_latch: assert property (
      EXC_TRIP_IN |=> STAT.trip_latched)
      else $error("trip not latched");
   a_mode_gate: assert property (
      $changed(STAT.reg_mode) |->
      STAT.digital_input_control || $past(STAT.digital_input_control))
      else $error("mode changed outside input control");
   a_unload_end: assert property (
      $rose(STAT.unload_timed_out) |-> $past(STAT.unload_active))
      else $error("timeout without unloading");
   a_bus_permit: assert property (
      $rose(STAT.bus_active) |->
      !(CFG.remote_permit_req && !CFG.remote_permit))
      else $error("bus active without permission");
endmodule

bind edi_handler edi_handler_props #(
   .MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_edi_handler_props (
   .SYS_CLK    (SYS_CLK),
   .NRST       (NRST),
   .DI_IN      (DI_IN),
   .CFG        (CFG),
   .EXC_TRIP_IN(EXC_TRIP_IN),
   .STAT       (STAT)
);

// file: verif/edi_switchgear.sv
`timescale 1ns/10ps
module edi_switchgear #(
   parameter int LAT = 5
) (
   input  wire logic SYS_CLK,
   input  wire logic NRST,
   input  wire logic open_order,
   input  wire logic close_order,
   input  wire logic trip,
   output logic      closed
);
   //---------------------------------------------
   // breaker mechanics
   //---------------------------------------------
   logic       want;
   logic [7:0] cnt;
   // open and trip beat close; else contacts stay put
   assign want = (open_order || trip) ? 1'b0 : close_order ? 1'b1 : closed;
   // contacts travel LAT+1 cycles, a slow breaker, not instant
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         closed <= 1'b0;
         cnt    <= 8'h00;
      end else if (want == closed) begin
         cnt <= 8'h00;
      end else if (cnt == 8'(LAT)) begin
         closed <= want;
         cnt    <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench
   import edi_pkg::*;
;
   //---------------------------------------------
   // bench
   //---------------------------------------------
   localparam int MS = 10;
   logic      clk = 1'b0;
   logic      nrst = 1'b0;
   logic      trip_in = 1'b0;
   logic      fbc;
   edi_di_s   di = '0;
   edi_di_s   din;
   edi_di_s   msk;
   edi_cfg_s  cfg;
   edi_stat_s stat;
   int        fails = 0;
   int        n_compared = 0;
   int        cyc = 0;
   int        m;

   edi_handler #(.MS_TICK_CYCLES(MS), .DEB_CNT(3)) u_edi_handler (
      .SYS_CLK    (clk),
      .NRST       (nrst),
      .DI_IN      (din),
      .CFG        (cfg),
      .EXC_TRIP_IN(trip_in),
      .STAT       (stat)
   );
   edi_switchgear #(.LAT(5)) u_edi_switchgear (
      .SYS_CLK    (clk),
      .NRST       (nrst),
      .open_order (stat.fb_open_order),
      .close_order(stat.fb_close_order),
      .trip       (stat.fb_trip),
      .closed     (fbc)
   );

   // 250 mhz
   always #2 clk = ~clk;
   // breaker contact comes from the switchgear model
   always_comb begin
      din = di;
      din.fb_closed = fbc;
   end
   // hang guard, the sequence needs under 2000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         give_verdict();
      end
   end

   task at(input int n);
      repeat (n) @(posedge clk);
   endtask
   // outputs are read mid-cycle, away from the edge race
   task look();
      @(negedge clk);
   endtask
   task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // held levels outlast debounce plus sync
   task lv(input edi_di_s v);
      at(1);
      di <= v;
      at(10);
      look();
   endtask
   task pls(input edi_di_s v);
      at(1);
      di <= di | v;
      at(10);
      di <= di & ~v;
      at(10);
      look();
   endtask
   task give_verdict();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      cfg = '{CTRL_DIGITAL_INPUT, DRIVE_NORMAL, 1'b0, 1'b0, 16'h3, 16'h2};
      at(4);
      nrst <= 1'b1;
      lv('0);
      chk("reg_mode", stat.reg_mode, MODE_VOLTAGE);
      chk("digital_input_control", stat.digital_input_control, 2'h1);
      lv('{raise:1, default:0});
      chk("ref_raise", stat.ref_raise, 2'h1);
      lv('{lower:1, default:0});
      chk("ref_lower", stat.ref_lower, 2'h1);
      lv('{raise:1, lower:1, default:0});
      chk("ref_both", {stat.ref_raise, stat.ref_lower}, 2'h0);
      lv('{test_raise:1, default:0});
      chk("test_raise", stat.ref_raise, 2'h0);
      at(1);
      cfg.force_drive <= DRIVE_FORCED_VALUE;
      lv('{test_raise:1, default:0});
      chk("test_raise", stat.ref_raise, 2'h1);
      at(1);
      cfg.force_drive <= DRIVE_OPEN_LOOP_REF;
      lv('{test_lower:1, default:0});
      chk("test_lower", stat.ref_lower, 2'h1);
      lv('0);
      // every regulator mode, voltage last
      for (m = 1; m <= 4; m++) begin
         msk = '0;
         {msk.cmd_voltage, msk.cmd_field, msk.cmd_reactive, msk.cmd_pf}
            = 4'h8 >> (m % 4);
         pls(msk);
         chk("reg_mode", stat.reg_mode, 2'(m % 4));
      end
      at(1);
      cfg.ctrl_mode <= CTRL_PANEL;
      pls('{cmd_pf:1, default:0});
      chk("digital_input_control", stat.digital_input_control, 2'h0);
      chk("reg_mode", stat.reg_mode, MODE_VOLTAGE);
      at(1);
      di.force_di <= 1'b1;
      pls('{cmd_pf:1, default:0});
      chk("reg_mode", stat.reg_mode, MODE_POWER_FACTOR);
      pls('{remote_bus:1, default:0});
      chk("bus_active", stat.bus_active, 2'h0);
      at(1);
      di.force_di <= 1'b0;
      cfg.remote_permit_req <= 1'b1;
      pls('{remote_bus:1, default:0});
      chk("bus_active", stat.bus_active, 2'h0);
      at(1);
      cfg.remote_permit <= 1'b1;
      cfg.ctrl_mode <= CTRL_DIGITAL_INPUT;
      pls('{remote_bus:1, default:0});
      chk("bus_active", stat.bus_active, 2'h1);
      pls('{cmd_voltage:1, default:0});
      chk("reg_mode", stat.reg_mode, MODE_POWER_FACTOR);
      at(1);
      di.force_di <= 1'b1;
      pls('{cmd_voltage:1, default:0});
      chk("bus_active", stat.bus_active, 2'h0);
      chk("reg_mode", stat.reg_mode, MODE_VOLTAGE);
      at(1);
      di.force_di <= 1'b0;
      pls('{unload_q:1, default:0});
      chk("unload_active", stat.unload_active, 2'h1);
      at(30);
      look();
      chk("unload_end", stat.unload_active, 2'h0);
      chk("timed_out", stat.unload_timed_out, 2'h1);
      pls('{close_fb:1, default:0});
      at(10);
      look();
      chk("fb_closed", stat.fb_closed, 2'h1);
      chk("close_order", stat.fb_close_order, 2'h0);
      pls('{exc_on:1, default:0});
      chk("exc_on", stat.exc_on, 2'h1);
      pls('{exc_off:1, default:0});
      chk("exc_on", stat.exc_on, 2'h0);
      pls('{exc_on:1, default:0});
      // trip: retard first, breaker opened afterwards
      at(1);
      di.incoming_trip <= 1'b1;
      at(14);
      look();
      chk("retard", stat.phase_retard, 2'h1);
      chk("fb_trip", stat.fb_trip, 2'h0);
      at(30);
      look();
      chk("fb_trip", stat.fb_trip, 2'h1);
      chk("retard", stat.phase_retard, 2'h0);
      chk("exc_on", stat.exc_on, 2'h0);
      chk("open_order", stat.fb_open_order, 2'h1);
      at(10);
      look();
      chk("fb_closed", stat.fb_closed, 2'h0);
      at(1);
      di.incoming_trip <= 1'b0;
      pls('{exc_on:1, default:0});
      chk("exc_on", stat.exc_on, 2'h0);
      pls('{trip_reset:1, default:0});
      chk("latched", stat.trip_latched, 2'h0);
      chk("fb_trip", stat.fb_trip, 2'h0);
      pls('{close_fb:1, default:0});
      chk("fb_closed", stat.fb_closed, 2'h1);
      pls('{open_fb:1, default:0});
      chk("fb_closed", stat.fb_closed, 2'h0);
      at(1);
      cfg.ctrl_mode <= CTRL_PANEL;
      pls('{close_fb:1, default:0});
      at(10);
      look();
      chk("fb_closed", stat.fb_closed, 2'h0);
      at(1);
      trip_in <= 1'b1;
      at(1);
      trip_in <= 1'b0;
      at(2);
      look();
      chk("latched", stat.trip_latched, 2'h1);
      give_verdict();
   end
endmodule

// file: verilog/edi_debounce.sv
`timescale 1ns/10ps
module edi_debounce
   import edi_pkg::*;
#(
   parameter int W   = DI_W,
   parameter int CNT = DEB_CYCLES
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   localparam int CW = (CNT > 1) ? $clog2(CNT) : 1;
   localparam logic [CW-1:0] CLAST = CW'(CNT - 1);

   if (CNT < 1 || W < 1) begin : g_chk
      $error("edi_debounce: CNT and W must be at least one");
   end

   logic [W-1:0]  sync1;
   logic [W-1:0]  sync2;
   logic [CW-1:0] cnt      [W];
   logic [CW-1:0] next_cnt [W];
   logic [W-1:0]  next_dout;

   //-------------------------------------------------------------------
   // a bit must differ for CNT cycles in a row before it flips
   //-------------------------------------------------------------------
   always_comb begin
      next_dout = dout;
      for (int i = 0; i < W; i++) begin
         next_cnt[i] = '0;
         if (sync2[i] != dout[i]) begin
            if (cnt[i] == CLAST) begin
               next_dout[i] = sync2[i];  // RULE_18
            end else begin
               next_cnt[i] = cnt[i] + 1'b1;
            end
         end
      end
   end

   // sync1 feeds sync2 only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= '0;
         sync2 <= '0;
         dout  <= '0;
         for (int i = 0; i < W; i++) begin
            cnt[i] <= '0;
         end
      end else begin
         sync1 <= din;  // RULE_18
         sync2 <= sync1;
         dout  <= next_dout;
         for (int i = 0; i < W; i++) begin
            cnt[i] <= next_cnt[i];
         end
      end
   end

endmodule

// file: verilog/edi_handler.sv
`timescale 1ns/10ps
module edi_handler
   import edi_pkg::*;
#(
   parameter int MS_TICK_CYCLES = MS_CYCLES,
   parameter int DEB_CNT        = DEB_CYCLES
) (
   input  wire logic      SYS_CLK,
   input  wire logic      NRST,
   input  wire edi_di_s   DI_IN,
   input  wire edi_cfg_s  CFG,
   input  wire logic      EXC_TRIP_IN,
   output edi_stat_s      STAT
);

   //-------------------------------------------------------------------
   // elaboration checks
   //-------------------------------------------------------------------
   localparam int MSW =
      (MS_TICK_CYCLES > 1) ? $clog2(MS_TICK_CYCLES) : 1;
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_TICK_CYCLES - 1);

   if (MS_TICK_CYCLES < 1 || DEB_CNT < 1) begin : g_chk
      $error("edi_handler: tick and debounce counts must be >= 1");
   end

   //-------------------------------------------------------------------
   // declarations
   //-------------------------------------------------------------------
   edi_di_s        deb;
   edi_di_s        prev;
   edi_di_s        rise;
   logic [MSW-1:0] ms_cnt;
   logic [MSW-1:0] next_ms_cnt;
   logic           ms_tick;
   logic           next_ms_tick;
   edi_trip_e      trip_state;
   edi_trip_e      next_trip_state;
   edi_stat_s      next_stat;
   logic           di_ctrl;
   logic           test_ok;
   logic           up_req;
   logic           down_req;
   logic           permit_ok;
   logic           unload_start;
   logic           unload_busy;
   logic           unload_done;
   logic           trip_start;
   logic           trip_busy;
   logic           trip_done;

   //-------------------------------------------------------------------
   // helper functions
   //-------------------------------------------------------------------
   // a gated command counts only in input control, never kept
   function automatic logic gate_cmd(input logic ctrl, input logic cmd);
      return ctrl & cmd;
   endfunction

   // true in retard or open, i.e. anywhere but idle
   function automatic logic in_trip(input edi_trip_e s);
      return s != TRIP_IDLE;
   endfunction

   // test stepping needs one of the two forced drive options
   function automatic logic test_drive(input edi_drive_e d);
      return d == DRIVE_FORCED_VALUE || d == DRIVE_OPEN_LOOP_REF;
   endfunction

   // fixed priority when several mode commands rise together
   function automatic edi_reg_mode_e pick_mode(
      input edi_di_s       r,
      input edi_reg_mode_e cur
   );
      pick_mode = cur;
      if (r.cmd_voltage) begin
         pick_mode = MODE_VOLTAGE;
      end else if (r.cmd_field) begin
         pick_mode = MODE_FIELD_CURRENT;
      end else if (r.cmd_reactive) begin
         pick_mode = MODE_REACTIVE;
      end else if (r.cmd_pf) begin
         pick_mode = MODE_POWER_FACTOR;
      end
   endfunction

   //-------------------------------------------------------------------
   // input conditioning
   //-------------------------------------------------------------------
   // every contact passes the same filter, so timing is uniform
   edi_debounce #(
      .W   (DI_W),
      .CNT (DEB_CNT)
   ) u_deb (
      .clk  (SYS_CLK),
      .nrst (NRST),
      .din  (DI_IN),
      .dout (deb)
   );

   // commands act once per assertion
   assign rise = deb & ~prev;  // RULE_18

   // last filtered levels, for edge detection
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         prev <= '0;
      end else begin
         prev <= deb;
      end
   end

   //-------------------------------------------------------------------
   // millisecond tick for the configured times
   //-------------------------------------------------------------------
   always_comb begin
      next_ms_tick = 1'b0;
      next_ms_cnt  = ms_cnt + 1'b1;
      if (ms_cnt == MS_LAST) begin
         next_ms_cnt  = '0;
         next_ms_tick = 1'b1;
      end
   end

   // tick is a flop, so both timers see it in one cycle
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ms_cnt  <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_cnt  <= next_ms_cnt;
         ms_tick <= next_ms_tick;
      end
   end

   //-------------------------------------------------------------------
   // control source
   //-------------------------------------------------------------------
   // forcing wins over panel and bus; bus steals local control
   assign di_ctrl = deb.force_di  // RULE_07
      | (CFG.ctrl_mode == CTRL_DIGITAL_INPUT & ~STAT.bus_active); // RULE_17

   // permission matters only where the setting demands it
   assign permit_ok = ~CFG.remote_permit_req | CFG.remote_permit;

   // test stepping only under a forced drive, in input control
   assign test_ok = di_ctrl & test_drive(CFG.force_drive);

   // raise and lower together cancel rather than fight
   assign up_req   = deb.raise  // RULE_01
      | (test_ok & deb.test_raise);  // RULE_03
   assign down_req = deb.lower  // RULE_02
      | (test_ok & deb.test_lower);  // RULE_04

   //-------------------------------------------------------------------
   // timers: reactive unload and stopping delay
   //-------------------------------------------------------------------
   assign unload_start = gate_cmd(di_ctrl, rise.unload_q)  // RULE_19
      & ~STAT.unload_active;

   // unloading is abandoned once a trip sequence starts
   edi_timer #(
      .W (TIME_W)
   ) u_unload (
      .clk   (SYS_CLK),
      .nrst  (NRST),
      .start (unload_start),
      .abort (in_trip(trip_state)),
      .len   (CFG.unload_timeout_ms),
      .tick  (ms_tick),
      .busy  (unload_busy),
      .done  (unload_done)
   );

   // level, so a trip still present after reset fires again
   assign trip_start = ~in_trip(trip_state) & deb.incoming_trip;

   // stopping delay, counted in millisecond ticks
   edi_timer #(
      .W (TIME_W)
   ) u_stop (
      .clk   (SYS_CLK),
      .nrst  (NRST),
      .start (trip_start),
      .abort (1'b0),
      .len   (CFG.stop_time_ms),
      .tick  (ms_tick),
      .busy  (trip_busy),
      .done  (trip_done)
   );

   //-------------------------------------------------------------------
   // trip sequence
   //-------------------------------------------------------------------
   // retard the firing first, open the breaker only after the wait
   always_comb begin
      next_trip_state = trip_state;
      case (trip_state)
         TRIP_IDLE: begin
            if (trip_start) begin
               next_trip_state = TRIP_RETARD;  // RULE_15
            end
         end
         TRIP_RETARD: begin
            if (trip_done) begin
               next_trip_state = TRIP_OPEN;  // RULE_16
            end
         end
         TRIP_OPEN: begin
            if (rise.trip_reset && !deb.incoming_trip) begin
               next_trip_state = TRIP_IDLE;
            end
         end
         default: begin
            next_trip_state = TRIP_IDLE;
         end
      endcase
   end

   // trip sequence state register
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         trip_state <= TRIP_IDLE;
      end else begin
         trip_state <= next_trip_state;
      end
   end

   //-------------------------------------------------------------------
   // status and orders
   //-------------------------------------------------------------------
   // one register for every status field, so outputs never glitch
   always_comb begin
      next_stat = STAT;

      // level outputs follow the filtered contacts
      next_stat.ref_raise  = up_req & ~down_req;
      next_stat.ref_lower  = down_req & ~up_req;
      next_stat.digital_input_control = di_ctrl;
      next_stat.fb_closed  = deb.fb_closed;  // RULE_10

      // bus activation; forcing drops it
      if (deb.force_di) begin
         next_stat.bus_active = 1'b0;  // RULE_07
      end else if (rise.remote_bus && permit_ok) begin
         next_stat.bus_active = 1'b1;  // RULE_06
      end

      // mode commands, fixed priority when several rise together
      if (di_ctrl) begin
         next_stat.reg_mode = pick_mode(rise, STAT.reg_mode);  // RULE_05
      end

      // reactive unloading
      next_stat.unload_active = unload_start | unload_busy;  // RULE_08
      if (unload_start) begin
         next_stat.unload_timed_out = 1'b0;
      end else if (unload_done) begin
         next_stat.unload_timed_out = 1'b1;
      end

      // trip latch: a new trip in the reset cycle survives
      if (deb.incoming_trip || EXC_TRIP_IN) begin
         next_stat.trip_latched = 1'b1;
      end else if (rise.trip_reset) begin
         next_stat.trip_latched = 1'b0;  // RULE_09
      end

      // excitation: off wins, on refused while tripped
      if (rise.exc_off || next_trip_state == TRIP_OPEN) begin
         next_stat.exc_on = 1'b0;  // RULE_11
      end else if (rise.exc_on && !next_stat.trip_latched) begin
         next_stat.exc_on = 1'b1;  // RULE_12
      end

      // trip state decoded one cycle ahead to stay registered
      next_stat.phase_retard = (next_trip_state == TRIP_RETARD);
      next_stat.fb_trip      = (next_trip_state == TRIP_OPEN);

      // open order holds until the breaker reports open
      next_stat.fb_open_order = next_stat.fb_trip  // RULE_16
         | gate_cmd(di_ctrl, rise.open_fb)  // RULE_13
         | (STAT.fb_open_order & deb.fb_closed);

      // close order holds until closed; any open request cancels it
      next_stat.fb_close_order = 1'b0;
      if (!in_trip(next_trip_state) && !next_stat.trip_latched
          && !next_stat.fb_open_order) begin
         next_stat.fb_close_order = (di_ctrl & rise.close_fb)  // RULE_14
            | (STAT.fb_close_order & ~deb.fb_closed);
      end
   end

   // reset keeps voltage regulation selected
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         STAT          <= '0;
         STAT.reg_mode <= RST_REG_MODE;
      end else begin
         STAT <= next_stat;
      end
   end

endmodule

// file: verilog/edi_timer.sv
`timescale 1ns/10ps
module edi_timer
   import edi_pkg::*;
#(
   parameter int W = TIME_W
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         start,
   input  wire logic         abort,
   input  wire logic [W-1:0] len,
   input  wire logic         tick,
   output logic              busy,
   output logic              done
);

   if (W < 1) begin : g_chk
      $error("edi_timer: W must be at least one");
   end

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_busy;
   logic         next_done;

   //-------------------------------------------------------------------
   // needs len+1 ticks: with an unaligned start the wait is never
   // shorter than len ticks, at most one tick longer
   //-------------------------------------------------------------------
   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      next_done = 1'b0;
      if (abort) begin
         next_busy = 1'b0;
      end else if (start) begin
         next_busy = 1'b1;
         next_cnt  = len;
      end else if (busy && tick) begin
         if (cnt == '0) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
         done <= next_done;
      end
   end

endmodule
